// *** core/sbsr_pkg.sv ***
/*
  Constants shared by the status summary byte and service request logic.
  Assumes the lower status registers deliver event and enable words on the
  same clock as this block.
*/
package sbsr_pkg;
  // ****************************************************
  // summary byte layout
  // ****************************************************
  localparam int unsigned ERRQ_POS = 2;
  localparam int unsigned QUES_POS = 3;
  localparam int unsigned MSG_POS = 4;
  localparam int unsigned EVT_POS = 5;
  localparam int unsigned MASTER_POS = 6;
  localparam int unsigned OPER_POS = 7;
  // ****************************************************
  // widths and reset values
  // ****************************************************
  localparam int unsigned SCPI_W = 16;
  localparam int unsigned ESR_W = 8;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  // positions 0, 1 and 6 never take part in the request decision
  localparam logic [7:0] REQ_MASK = 8'hbc;
endpackage

// *** core/masked_sum.sv ***
/*
  Sum bit of one lower status register: AND of each event bit with its
  enable bit, ORed together, held in a flip-flop.
  Assumes event and enable words come from logic on the same clock.
*/
module masked_sum #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // event and enable words
  input wire logic [WIDTH-1:0] event_i,
  input wire logic [WIDTH-1:0] enable_i,
  // registered sum bit
  output logic sum_o
);
  wire logic next_sum;

  assign next_sum = |(event_i & enable_i);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sum_o <= 1'b0;
    end else begin
      sum_o <= next_sum;
    end
  end

  chk_sum_follows: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ##1 sum_o == |($past(event_i) & $past(enable_i)))
    else $error("sum bit does not follow event and enable");
endmodule

// *** core/status_byte_service_request.sv ***
/*
  Top of the status reporting tree: builds the status summary byte from the
  error queue, output buffer and lower register sum bits, masks it with the
  request enable register and raises the master summary and service request.
  Assumes all inputs come from logic on clock_i; the request enable register
  is written by the command decoder with a one-cycle write strobe.
*/
// What this block does
// - position 2 set on new error entry
// - enabled position 2 requests on every entry
// - position 3 is questionable register sum
// - position 4 flags readable output message
// - position 5 is event status register sum
// - position 6 is OR of enabled bits
// - position 7 is operation register sum
// - enable mask position 6 is ignored
// - request on enabled rising edge or enabled error entry
// - sums are OR of ANDed event, enable
module status_byte_service_request
  import sbsr_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // error queue
  input wire logic err_entry_write_i,
  input wire logic err_queue_not_empty_i,
  // output buffer
  input wire logic output_msg_ready_i,
  // event status register and its enable
  input wire logic [ESR_W-1:0] esr_event_i,
  input wire logic [ESR_W-1:0] esr_enable_i,
  // questionable register event and enable parts
  input wire logic [SCPI_W-1:0] ques_event_i,
  input wire logic [SCPI_W-1:0] ques_enable_i,
  // operation register event and enable parts
  input wire logic [SCPI_W-1:0] oper_event_i,
  input wire logic [SCPI_W-1:0] oper_enable_i,
  // request enable register access
  input wire logic sre_write_i,
  input wire logic [7:0] sre_data_i,
  // status outputs
  output logic [7:0] status_summary_byte_o,
  output logic [7:0] sre_o,
  output logic master_summary_flag_o,
  output logic service_request_o
);
  // ****************************************************
  // lower register sum bits
  // ****************************************************
  wire logic ques_sum;
  wire logic oper_sum;
  wire logic event_summary_flag;

  masked_sum #(.WIDTH(SCPI_W)) u_ques_sum (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .event_i(ques_event_i),
    .enable_i(ques_enable_i),
    .sum_o(ques_sum)
  );

  masked_sum #(.WIDTH(SCPI_W)) u_oper_sum (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .event_i(oper_event_i),
    .enable_i(oper_enable_i),
    .sum_o(oper_sum)
  );

  masked_sum #(.WIDTH(ESR_W)) u_esr_sum (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .event_i(esr_event_i),
    .enable_i(esr_enable_i),
    .sum_o(event_summary_flag)
  );

  // ****************************************************
  // error queue and message flags
  // ****************************************************
  // the entry strobe also sets the flag so a fresh entry shows even if the
  // queue's own count lags by a cycle
  logic err_flag;
  logic err_entry_seen;
  logic message_available_flag;
  wire logic next_err_flag;

  assign next_err_flag = err_entry_write_i | err_queue_not_empty_i;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_flag <= 1'b0;
      err_entry_seen <= 1'b0;
      message_available_flag <= 1'b0;
    end else begin
      err_flag <= next_err_flag;
      err_entry_seen <= err_entry_write_i;
      message_available_flag <= output_msg_ready_i;
    end
  end

  // ****************************************************
  // summary byte and request decision
  // ****************************************************
  wire logic [7:0] sum_bits;
  wire logic [7:0] sre_eff;
  wire logic [7:0] rising;
  wire logic next_master;
  wire logic next_request;

  assign sum_bits = {oper_sum, 1'b0, event_summary_flag,
                     message_available_flag, ques_sum, err_flag,
                     2'b00};
  assign sre_eff = sre_o & REQ_MASK;
  assign next_master = |(sum_bits & sre_eff);
  assign rising = sum_bits & ~status_summary_byte_o & sre_eff;
  // a new entry requests even while the queue flag already stands
  assign next_request = (|rising) |
                        (err_entry_seen & sre_eff[ERRQ_POS]);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_summary_byte_o <= SUMMARY_RESET;
      master_summary_flag_o <= 1'b0;
      service_request_o <= 1'b0;
    end else begin
      status_summary_byte_o <= {sum_bits[7], next_master, sum_bits[5:0]};
      master_summary_flag_o <= next_master;
      service_request_o <= next_request;
    end
  end

  // ****************************************************
  // request enable register
  // ****************************************************
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sre_o <= SRE_RESET;
    end else if (sre_write_i) begin
      sre_o <= sre_data_i;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // inputs reach the byte two edges after they are sampled: the sum or
  // flag stage, then the byte stage; the properties below count on that

  chk_low_bits_zero: assert property (
    status_summary_byte_o[1:0] == 2'b00)
    else $error("low summary positions not zero");

  chk_err_entry_sets: assert property (
    err_entry_write_i |-> ##2 status_summary_byte_o[ERRQ_POS])
    else $error("error entry did not set queue flag");

  chk_entry_requests: assert property (
    err_entry_write_i && sre_o[ERRQ_POS] && !sre_write_i
    |-> ##2 service_request_o)
    else $error("enabled error entry gave no request");

  chk_ques_position: assert property (
    ##2 status_summary_byte_o[QUES_POS] ==
      |($past(ques_event_i, 2) & $past(ques_enable_i, 2)))
    else $error("questionable sum position wrong");

  chk_msg_position: assert property (
    output_msg_ready_i |-> ##2 status_summary_byte_o[MSG_POS])
    else $error("message flag not set");

  chk_evt_position: assert property (
    ##2 status_summary_byte_o[EVT_POS] ==
      |($past(esr_event_i, 2) & $past(esr_enable_i, 2)))
    else $error("event summary position wrong");

  chk_oper_position: assert property (
    ##2 status_summary_byte_o[OPER_POS] ==
      |($past(oper_event_i, 2) & $past(oper_enable_i, 2)))
    else $error("operation sum position wrong");

  chk_master_match: assert property (
    master_summary_flag_o == status_summary_byte_o[MASTER_POS] &&
    master_summary_flag_o ==
      |(status_summary_byte_o & $past(sre_o) & REQ_MASK))
    else $error("master summary mismatch");

  chk_mask6_ignored: assert property (
    $past(sre_o) == 8'h40 |-> !master_summary_flag_o)
    else $error("mask position 6 took effect");

  chk_request_cause: assert property (
    service_request_o |->
      (|(status_summary_byte_o & ~$past(status_summary_byte_o) &
         $past(sre_o) & REQ_MASK)) ||
      ($past(err_entry_seen) && $past(sre_o[ERRQ_POS])))
    else $error("request without enabled rising edge");

  // the converse: every enabled 0 to 1 step of the byte must request
  chk_rise_requests: assert property (
    |(status_summary_byte_o & ~$past(status_summary_byte_o) &
      $past(sre_o) & REQ_MASK) |-> service_request_o)
    else $error("enabled rising edge gave no request");

  cov_error_request: cover property (
    err_entry_write_i ##2 service_request_o);
  cov_msg_request: cover property (
    sre_o[MSG_POS] ##0 output_msg_ready_i ##2 service_request_o);
  cov_oper_master: cover property (
    master_summary_flag_o && status_summary_byte_o[OPER_POS]);
  cov_repeat_entry: cover property (
    status_summary_byte_o[ERRQ_POS] ##0 err_entry_write_i
    ##2 service_request_o);
  cov_mask6_only: cover property (
    $past(sre_o) == 8'h40 && status_summary_byte_o[MSG_POS]);
endmodule

// *** test/sbsr_host.sv ***
/*
  Remote controller model: counts service requests and polls the byte.
  Assumes the outputs it watches are registered on clock_i.
*/
module sbsr_host (
  // watched outputs
  input wire logic clock_i,
  input wire logic service_request_i,
  input wire logic [7:0] summary_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int srq_count = 0;
  logic [7:0] polled = 8'h00;
  // a poll per request stands in for reading the queue or the answer
  always @(posedge clock_i) begin
    if (service_request_i === 1'b1) begin
      srq_count <= srq_count + 1;
      polled <= summary_i;
    end
  end
endmodule

// *** test/tb_status_byte_service_request.sv ***
/*
  Testbench of the status summary byte: directed sources, mask writes.
  Assumes two cycles from input to byte and a registered request pulse.
*/
module tb_status_byte_service_request;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic err_entry_write_i, err_queue_not_empty_i, output_msg_ready_i;
  logic [7:0] esr_event_i, esr_enable_i, sre_data_i;
  logic [15:0] ques_event_i, ques_enable_i, oper_event_i, oper_enable_i;
  logic sre_write_i;
  logic [7:0] status_summary_byte_o, sre_o;
  logic master_summary_flag_o, service_request_o;
  int fails = 0;
  int cmp_count = 0;
  int n;
  int pos[5] = '{2, 3, 4, 5, 7};

  always #10 clock_i = ~clock_i;

  status_byte_service_request uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .err_entry_write_i(err_entry_write_i),
    .err_queue_not_empty_i(err_queue_not_empty_i),
    .output_msg_ready_i(output_msg_ready_i),
    .esr_event_i(esr_event_i), .esr_enable_i(esr_enable_i),
    .ques_event_i(ques_event_i), .ques_enable_i(ques_enable_i),
    .oper_event_i(oper_event_i), .oper_enable_i(oper_enable_i),
    .sre_write_i(sre_write_i), .sre_data_i(sre_data_i),
    .status_summary_byte_o(status_summary_byte_o), .sre_o(sre_o),
    .master_summary_flag_o(master_summary_flag_o),
    .service_request_o(service_request_o));

  sbsr_host host (.clock_i(clock_i), .service_request_i(service_request_o),
    .summary_i(status_summary_byte_o));

  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sre_wr(input logic [7:0] d);
    sre_data_i = d;
    sre_write_i = 1'b1;
    tick(1);
    sre_write_i = 1'b0;
    tick(1);
  endtask

  task automatic src(input int p, input logic v);
    case (p)
      2: err_queue_not_empty_i = v;
      3: ques_event_i = {15'h0000, v};
      4: output_msg_ready_i = v;
      5: esr_event_i = {7'h00, v};
      7: oper_event_i = {15'h0000, v};
      default: ;
    endcase
  endtask

  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********
  // stimulus
  // ********
  initial begin
    {err_entry_write_i, err_queue_not_empty_i, output_msg_ready_i} = 3'h0;
    {esr_event_i, ques_event_i, oper_event_i} = 40'h00_0000_0000;
    {esr_enable_i, ques_enable_i, oper_enable_i} = 40'hff_ffff_ffff;
    sre_write_i = 1'b0;
    sre_data_i = 8'h00;
    repeat (3) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    tick(1);
    chk(status_summary_byte_o, 8'h00);
    chk(sre_o, 8'h00);
    sre_wr(8'hff);
    chk(sre_o, 8'hff);
    foreach (pos[i]) begin
      src(pos[i], 1'b1);
      tick(2);
      chk(status_summary_byte_o, 8'h40 | (8'h01 << pos[i]));
      chk({7'h00, master_summary_flag_o}, 8'h01);
      chk({7'h00, service_request_o}, 8'h01);
      tick(1);
      chk({7'h00, service_request_o}, 8'h00);
      chk(host.polled, 8'h40 | (8'h01 << pos[i]));
      src(pos[i], 1'b0);
      tick(3);
      chk(status_summary_byte_o, 8'h00);
    end
    // event bit without its enable must not reach the sum
    ques_event_i = 16'h0001;
    ques_enable_i = 16'hfffe;
    tick(3);
    chk(status_summary_byte_o, 8'h00);
    ques_event_i = 16'h0000;
    sre_wr(8'h40);
    output_msg_ready_i = 1'b1;
    tick(3);
    chk(status_summary_byte_o, 8'h10);
    n = host.srq_count;
    // enabling a bit that is already set raises master but no request
    sre_wr(8'h10);
    tick(2);
    chk(status_summary_byte_o, 8'h50);
    chk(8'(host.srq_count - n), 8'h00);
    sre_wr(8'h04);
    output_msg_ready_i = 1'b0;
    n = host.srq_count;
    repeat (2) begin
      err_entry_write_i = 1'b1;
      tick(1);
      err_entry_write_i = 1'b0;
      err_queue_not_empty_i = 1'b1;
      tick(3);
    end
    chk(8'(host.srq_count - n), 8'h02);
    chk(status_summary_byte_o, 8'h44);
    chk(host.polled, 8'h44);
    finish_test();
  end

  initial begin
    repeat (2000) @(posedge clock_i);
    fails++;
    finish_test();
  end
endmodule
